// ### core/xspi_mem_pins.sv
// xSPI persistent memory pin front end: transaction framing, lane sampling,
// read drive with data strobe, pin reset, interrupt and write protect.
// Assumes SYS_CLK oversamples CK by at least four; command decode lies outside.
//
// Operation
// - Falling chip select starts a new command sequence.
// - Rising chip select ends or abandons the current sequence.
// - Sample on CK rising, or both edges in DTR; CK may stop.
// - Command, address and data use shared data lines, up to eight.
// - Drive a data strobe for capturing read data when commands use it.
// - While hardware reset is low, reinitialise, then return ready.
// - While hardware reset is low, strobe and all data lines float.
// - Pull open-drain interrupt low when an internal event is pending and hardware reset is high.
// - Write protect locks status only together with status bit seven.
// - On ball array, shared lane 2 write protect acts only in single mode.
// - On eight-pin part, lane 3 is reset in single and dual modes, data otherwise.
// - Quad-only parts leave the upper four lanes unimplemented.
// - Octal mode sustains transfers on eight lanes at full clock rate.
// - Strobe low while receiving, toggles while driving read data.
// - Protect bit set and write protect low blocks status register writes.
`timescale 1ns/1ps
module xspi_mem_pins
   import xspi_pin_pkg::*;
#(
   parameter bit DFN_PACKAGE = 1'b0,
   parameter bit QUAD_ONLY = 1'b0
) (
   input wire logic SYS_CLK,                    // System clock, 200 MHz
   input wire logic RST_N,                      // Async reset, active low
   input wire logic CS_N,                       // Chip select pin
   input wire logic CK,                         // Link clock pin
   input wire logic [7:0] IO_IN,                // Data lines, input side
   output logic [7:0] IO_OUT,                   // Data lines, output side
   output logic [7:0] IO_OE,                    // Data lines, high while driven
   output logic DS_OUT,                         // Data strobe level
   output logic DS_OE,                          // Data strobe drive enable
   input wire logic HW_RESET_N,                 // Dedicated reset ball
   output logic INT_OUT,                        // Interrupt pin level, always 0
   output logic INT_OE,                         // Interrupt pull-down enable
   input wire logic [1:0] MODE_WIDTH,           // Protocol width code
   input wire logic MODE_DTR,                   // Double transfer rate
   input wire logic EVENT_PENDING,              // Internal event level
   input wire logic [7:0] STATUS_REG,           // Current status register
   input wire logic SR_WRITE_REQ,               // Status write request pulse
   output logic SR_WRITE_GO,                    // Status write allowed pulse
   output logic SR_LOCKED,                      // Status register locked level
   input wire logic TX_ACTIVE,                  // Read data phase level
   input wire logic [7:0] TX_DATA,              // Next read byte
   output logic TX_TAKE,                        // Read byte consumed pulse
   output logic [7:0] RX_DATA,                  // Received byte
   output logic RX_VALID,                       // Received byte pulse
   output logic FRAME_START,                    // Transaction start pulse
   output logic FRAME_END,                      // Transaction end, pulse on deselect, held high during pin reset in a frame
   output logic HW_RESET_ACTIVE                 // Pin reset in progress
);
   // ==========================================================
   // Helpers
   function automatic logic [3:0] width_bits(input logic [1:0] code);
      unique case (code)
         WIDTH_X1: width_bits = 4'h1;
         WIDTH_X2: width_bits = 4'h2;
         WIDTH_X4: width_bits = 4'h4;
         WIDTH_X8: width_bits = 4'h8;
      endcase
   endfunction : width_bits

   function automatic logic [7:0] lane_mask(input logic [1:0] code);
      unique case (code)
         WIDTH_X1: lane_mask = LANES_X1_IN;
         WIDTH_X2: lane_mask = LANES_X2;
         WIDTH_X4: lane_mask = LANES_X4;
         WIDTH_X8: lane_mask = LANES_X8;
      endcase
   endfunction : lane_mask

   // ==========================================================
   // Pin synchronisers
   logic cs_n_s;
   logic ck_s;
   logic rst_pin_n_s;
   logic [7:0] io_s;

   xspi_sync #(.WIDTH(11), .INIT(11'h603)) u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d({CS_N, HW_RESET_N, CK, IO_IN}),
      .q({cs_n_s, rst_pin_n_s, ck_s, io_s})
   );

   // ==========================================================
   // Mode and shared terminals
   logic ck_d_r;
   logic cs_n_d_r;
   logic [1:0] width_code;
   logic [3:0] wbits;
   logic single_or_dual;
   logic hw_rst;
   logic wp_low;

   assign width_code = (QUAD_ONLY && MODE_WIDTH == WIDTH_X8) ? WIDTH_X4 : MODE_WIDTH;
   assign wbits = width_bits(width_code);
   assign single_or_dual = (width_code == WIDTH_X1) || (width_code == WIDTH_X2);
   // Eight-pin part: lane 3 is reset only in single and dual modes
   assign hw_rst = DFN_PACKAGE ? (single_or_dual && !io_s[RESET_LANE]) : !rst_pin_n_s;
   assign wp_low = (width_code == WIDTH_X1) && !io_s[WP_LANE];

   // ==========================================================
   // Edges and framing
   logic ck_rise;
   logic ck_fall;
   logic cs_fall;
   logic cs_rise;
   logic in_frame;
   logic rx_edge;
   logic tx_edge;

   assign ck_rise = ck_s && !ck_d_r;
   assign ck_fall = !ck_s && ck_d_r;
   assign cs_fall = !cs_n_s && cs_n_d_r;
   assign cs_rise = cs_n_s && !cs_n_d_r;
   assign in_frame = !cs_n_s && !hw_rst;
   assign rx_edge = in_frame && (ck_rise || (MODE_DTR && ck_fall));
   assign tx_edge = in_frame && (ck_fall || (MODE_DTR && ck_rise));

   // ==========================================================
   // Receive path
   logic [7:0] rx_sh_r;
   logic [3:0] rx_cnt_r;
   logic [7:0] rx_sh_nxt;
   logic [3:0] rx_cnt_nxt;
   logic rx_full;

   assign rx_sh_nxt = 8'((rx_sh_r << wbits) | (io_s & lane_mask(width_code)));
   assign rx_cnt_nxt = rx_cnt_r + wbits;
   assign rx_full = (rx_cnt_nxt == BYTE_BITS);

   // ==========================================================
   // Transmit path
   logic [7:0] tx_sh_r;
   logic [3:0] tx_cnt_r;
   logic tx_on_r;
   logic tx_start;
   logic tx_step;
   logic tx_reload;
   logic [7:0] tx_sh_nxt;
   logic [7:0] out_lanes;
   logic [7:0] out_mask;

   assign tx_start = in_frame && TX_ACTIVE && !tx_on_r;
   assign tx_step = tx_on_r && tx_edge;
   assign tx_reload = tx_step && (tx_cnt_r + wbits == BYTE_BITS);
   assign tx_sh_nxt = tx_reload ? TX_DATA : 8'(tx_sh_r << wbits);
   // Single mode drives its one output bit on lane 1
   assign out_lanes = (width_code == WIDTH_X1) ? {6'h00, tx_sh_nxt[7], 1'b0}
                                               : 8'(tx_sh_nxt >> (BYTE_BITS - wbits));
   assign out_mask = (width_code == WIDTH_X1) ? LANES_X1_OUT : lane_mask(width_code);

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ck_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         ck_d_r <= ck_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   // Framing pulses and receive assembly
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_sh_r <= SHIFT_RST;
         rx_cnt_r <= COUNT_RST;
         RX_DATA <= SHIFT_RST;
         RX_VALID <= 1'b0;
         FRAME_START <= 1'b0;
         FRAME_END <= 1'b0;
      end else begin
         FRAME_START <= cs_fall && !hw_rst;
         FRAME_END <= cs_rise || (hw_rst && !cs_n_s);
         RX_VALID <= rx_edge && !tx_on_r && rx_full;
         if (!in_frame || cs_fall) begin
            rx_sh_r <= SHIFT_RST;
            rx_cnt_r <= COUNT_RST;
         end else if (rx_edge && !tx_on_r) begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_full ? COUNT_RST : rx_cnt_nxt;
            if (rx_full) begin
               RX_DATA <= rx_sh_nxt;
            end
         end
      end
   end

   // Read data drive and strobe
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_sh_r <= SHIFT_RST;
         tx_cnt_r <= COUNT_RST;
         tx_on_r <= 1'b0;
         TX_TAKE <= 1'b0;
         IO_OUT <= 8'h00;
         IO_OE <= 8'h00;
         DS_OUT <= 1'b0;
         DS_OE <= 1'b0;
      end else begin
         TX_TAKE <= tx_start || tx_reload;
         DS_OE <= in_frame;
         if (!in_frame || !TX_ACTIVE) begin
            tx_on_r <= 1'b0;
            tx_cnt_r <= COUNT_RST;
            IO_OE <= 8'h00;
            DS_OUT <= 1'b0;
         end else if (tx_start) begin
            tx_on_r <= 1'b1;
            tx_sh_r <= TX_DATA;
            tx_cnt_r <= COUNT_RST;
            IO_OUT <= (width_code == WIDTH_X1) ? {6'h00, TX_DATA[7], 1'b0}
                                               : 8'(TX_DATA >> (BYTE_BITS - wbits));
            IO_OE <= out_mask;
         end else if (tx_step) begin
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_reload ? COUNT_RST : tx_cnt_r + wbits;
            IO_OUT <= out_lanes;
            IO_OE <= out_mask;
            DS_OUT <= !DS_OUT;
         end
      end
   end

   // Interrupt, write protect and reset status
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         INT_OUT <= 1'b0;
         INT_OE <= 1'b0;
         SR_LOCKED <= 1'b0;
         SR_WRITE_GO <= 1'b0;
         HW_RESET_ACTIVE <= 1'b0;
      end else begin
         INT_OUT <= 1'b0;
         INT_OE <= EVENT_PENDING && !hw_rst;
         SR_LOCKED <= STATUS_REG[SR_PROTECT_POS] && wp_low;
         SR_WRITE_GO <= SR_WRITE_REQ && !hw_rst &&
                        !(STATUS_REG[SR_PROTECT_POS] && wp_low);
         HW_RESET_ACTIVE <= hw_rst;
      end
   end
endmodule : xspi_mem_pins

// ### core/xspi_pin_pkg.sv
// Constants shared by the xSPI memory pin front end.
// Assumes a single system clock that oversamples the link clock.
package xspi_pin_pkg;
   // Protocol width codes
   localparam logic [1:0] WIDTH_X1 = 2'h0;
   localparam logic [1:0] WIDTH_X2 = 2'h1;
   localparam logic [1:0] WIDTH_X4 = 2'h2;
   localparam logic [1:0] WIDTH_X8 = 2'h3;
   // Bits in one transfer unit
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Lane masks
   localparam logic [7:0] LANES_X1_IN = 8'h01;
   localparam logic [7:0] LANES_X1_OUT = 8'h02;
   localparam logic [7:0] LANES_X2 = 8'h03;
   localparam logic [7:0] LANES_X4 = 8'h0F;
   localparam logic [7:0] LANES_X8 = 8'hFF;
   // Lane positions of shared terminals
   localparam int WP_LANE = 2;
   localparam int RESET_LANE = 3;
   // Status register protect enable bit position
   localparam int SR_PROTECT_POS = 7;
   // Reset values
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [3:0] COUNT_RST = 4'h0;
endpackage : xspi_pin_pkg

// ### core/xspi_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module xspi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,             // Sampling clock
   input wire logic rst_n,           // Async reset, active low
   input wire logic [WIDTH-1:0] d,   // Asynchronous input
   output logic [WIDTH-1:0] q        // Synchronised output
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : xspi_sync

// ### tb/xspi_mem_pins_monitor.sv
// Checker for the xSPI memory pin front end.
// Assumes it is bound to xspi_mem_pins; one clock domain.
`timescale 1ns/1ps
module xspi_mem_pins_monitor
   import xspi_pin_pkg::*;
(
   input wire logic SYS_CLK, // Clock
   input wire logic RST_N, // Reset
   input wire logic CS_N, // Select
   input wire logic [1:0] MODE_WIDTH, // Width
   input wire logic EVENT_PENDING, // Event
   input wire logic SR_WRITE_REQ, // Request
   input wire logic SR_WRITE_GO, // Allowed
   input wire logic SR_LOCKED, // Locked
   input wire logic [7:0] IO_OE, // Enables
   input wire logic DS_OUT, // Strobe
   input wire logic DS_OE, // Strobe enable
   input wire logic INT_OUT, // Interrupt level
   input wire logic INT_OE, // Interrupt enable
   input wire logic RX_VALID, // Byte pulse
   input wire logic FRAME_START, // Start pulse
   input wire logic HW_RESET_ACTIVE // Pin reset
);
   // ====
   // Properties
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence cs_fall;
      $fell(CS_N) && !HW_RESET_ACTIVE;
   endsequence
   sequence locked_twice;
      SR_LOCKED && $past(SR_LOCKED);
   endsequence
   chk_frame_start: assert property (cs_fall |-> ##[2:4] FRAME_START) else $error("no frame start");
   chk_int_idle: assert property (!EVENT_PENDING |=> !INT_OE) else $error("interrupt without event");
   chk_int_low: assert property (INT_OUT == 1'b0) else $error("interrupt level high");
   chk_reset_float: assert property (HW_RESET_ACTIVE [*2] |-> IO_OE == 8'h00 && !DS_OE) else $error("drive in reset");
   chk_sr_cause: assert property (SR_WRITE_GO |-> $past(SR_WRITE_REQ)) else $error("write go without request");
   chk_sr_block: assert property ((SR_WRITE_REQ and locked_twice) |=> !SR_WRITE_GO) else $error("locked write went");
   chk_lock_mode: assert property (SR_LOCKED |-> $past(MODE_WIDTH) == WIDTH_X1) else $error("lock outside x1");
   chk_rx_pulse: assert property (RX_VALID |=> !RX_VALID) else $error("byte pulse too long");
   chk_ds_quiet: assert property (IO_OE == 8'h00 |-> !DS_OUT) else $error("strobe high while receiving");
   chk_x1_lane: assert property (IO_OE != 8'h00 && $past(MODE_WIDTH) == WIDTH_X1 |-> IO_OE == LANES_X1_OUT)
      else $error("wrong x1 read lane");
endmodule : xspi_mem_pins_monitor

// ### tb/xspi_host_model.sv
// Host controller model: select, link clock and host lane drive.
// Assumes the bench resolves lanes against the memory's enables.
`timescale 1ns/1ps
module xspi_host_model (
   output logic cs_n, // Select
   output logic ck, // Link clock, stopped outside frames
   output logic [7:0] io // Host lane drive
);
   initial begin
      cs_n = 1'b1;
      ck = 1'b0;
      io = 8'h08;
   end
   task automatic open_frame();
      cs_n = 1'b0;
      #62.5;
   endtask : open_frame
   task automatic close_frame();
      io[3] = 1'b1;
      #62.5;
      cs_n = 1'b1;
      io = ~io | 8'h08;
      #62.5;
   endtask : close_frame
   task automatic pulse_ck();
      ck = 1'b1;
      #62.5;
      ck = 1'b0;
      #62.5;
   endtask : pulse_ck
   // Whole units only, high part first; DTR callers send byte pairs
   task automatic send_byte(input logic [1:0] w, input logic dtr, input logic [7:0] b);
      logic [7:0] s;
      int n;
      n = 1 << w;
      for (int i = 0; i < 8 / n; i++) begin
         s = b << (i * n);
         io = (s >> (8 - n)) | ((n < 4) ? 8'h08 : 8'h00);
         #31.25;
         ck = ~ck;
         #31.25;
         if (!dtr) begin
            #31.25;
            ck = 1'b0;
            #31.25;
         end
      end
   endtask : send_byte
endmodule : xspi_host_model

// ### tb/xspi_mem_pins_tb.sv
// Self-checking bench for the xSPI memory pin front end.
// Assumes the host model drives the link; lane levels resolved here.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module xspi_mem_pins_tb;
   import xspi_pin_pkg::*;
   logic clk, rst_n, hw_n, dtr, ev, req, txa, cs_n, ck, ds_out, ds_oe, int_out, int_oe, go, lck, take, rxv, fs, fe, hwa;
   logic [1:0] mw;
   logic [7:0] sr, txd, io_out, io_oe, io_in, host_io, rxd, rx_last, rx_first, oe2, out2;
   logic hwa2;
   int num_errors = 0, checked = 0, rx_count = 0, starts = 0, ends = 0, takes = 0;
   assign io_in = (io_oe & io_out) | (~io_oe & host_io);
   xspi_host_model i_host (.cs_n(cs_n), .ck(ck), .io(host_io));
   xspi_mem_pins i_dut (.SYS_CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .CK(ck), .IO_IN(io_in), .IO_OUT(io_out),
      .IO_OE(io_oe), .DS_OUT(ds_out), .DS_OE(ds_oe), .HW_RESET_N(hw_n), .INT_OUT(int_out), .INT_OE(int_oe),
      .MODE_WIDTH(mw), .MODE_DTR(dtr), .EVENT_PENDING(ev), .STATUS_REG(sr), .SR_WRITE_REQ(req), .SR_WRITE_GO(go),
      .SR_LOCKED(lck), .TX_ACTIVE(txa), .TX_DATA(txd), .TX_TAKE(take), .RX_DATA(rxd), .RX_VALID(rxv),
      .FRAME_START(fs), .FRAME_END(fe), .HW_RESET_ACTIVE(hwa));
   // Eight-pin, quad-only variant watching the same link
   xspi_mem_pins #(.DFN_PACKAGE(1'b1), .QUAD_ONLY(1'b1)) i_dut_dfn (.SYS_CLK(clk), .RST_N(rst_n), .CS_N(cs_n),
      .CK(ck), .IO_IN(io_in), .IO_OUT(out2), .IO_OE(oe2), .DS_OUT(), .DS_OE(), .HW_RESET_N(hw_n), .INT_OUT(),
      .INT_OE(), .MODE_WIDTH(mw), .MODE_DTR(dtr), .EVENT_PENDING(ev), .STATUS_REG(sr), .SR_WRITE_REQ(req),
      .SR_WRITE_GO(), .SR_LOCKED(), .TX_ACTIVE(txa), .TX_DATA(txd), .TX_TAKE(), .RX_DATA(), .RX_VALID(),
      .FRAME_START(), .FRAME_END(), .HW_RESET_ACTIVE(hwa2));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rxv === 1'b1) begin
         if (rx_count == 0) rx_first <= rxd;
         rx_last <= rxd;
         rx_count++;
      end
      if (fs === 1'b1) starts++;
      if (take === 1'b1) takes++;
      if (fe === 1'b1 && hwa !== 1'b1) ends++;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic t_rx();
      for (int w = 0; w < 4; w++) begin
         @(negedge clk);
         mw = w[1:0];
         dtr = (w == 3);
         rx_count = 0;
         starts = 0;
         ends = 0;
         i_host.open_frame();
         i_host.send_byte(w[1:0], w == 3, 8'h3C ^ 8'(w));
         i_host.send_byte(w[1:0], w == 3, 8'hA6);
         i_host.close_frame();
         `CHECK("rx count", 2, rx_count);
         `CHECK("rx first", 8'h3C ^ 8'(w), rx_first);
         `CHECK("rx last", 8'hA6, rx_last);
         `CHECK("frame start", 1, starts);
         `CHECK("frame end", 1, ends);
      end
      $display("test rx done");
   endtask : t_rx
   task automatic t_read();
      logic [2:0] bits;
      @(negedge clk);
      mw = WIDTH_X1;
      dtr = 1'b0;
      txd = 8'hC3;
      i_host.open_frame();
      @(negedge clk);
      takes = 0;
      txa = 1'b1;
      repeat (4) @(negedge clk);
      `CHECK("read lanes", LANES_X1_OUT, io_oe);
      `CHECK("strobe enable", 1'b1, ds_oe);
      bits[2] = io_out[1];
      i_host.pulse_ck();
      bits[1] = io_out[1];
      `CHECK("strobe toggle", 1'b1, ds_out);
      i_host.pulse_ck();
      bits[0] = io_out[1];
      `CHECK("read bits", 3'h6, bits);
      `CHECK("read take", 1, takes);
      txa = 1'b0;
      repeat (4) @(negedge clk);
      `CHECK("read release", 8'h00, io_oe);
      i_host.close_frame();
      $display("test read done");
   endtask : t_read
   task automatic sr_try(input logic wp, input logic [1:0] w, input logic [7:0] s, input logic el, input logic eg);
      @(negedge clk);
      i_host.io[2] = wp;
      mw = w;
      sr = s;
      repeat (5) @(negedge clk);
      `CHECK("locked", el, lck);
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      `CHECK("write go", eg, go);
   endtask : sr_try
   task automatic t_sr();
      sr_try(1'b0, WIDTH_X1, 8'h80, 1'b1, 1'b0);
      sr_try(1'b1, WIDTH_X1, 8'h80, 1'b0, 1'b1);
      sr_try(1'b0, WIDTH_X1, 8'h7F, 1'b0, 1'b1);
      sr_try(1'b0, WIDTH_X4, 8'h80, 1'b0, 1'b1);
      $display("test status done");
   endtask : t_sr
   task automatic t_int_rst();
      @(negedge clk);
      mw = WIDTH_X1;
      ev = 1'b1;
      txa = 1'b1;
      repeat (3) @(negedge clk);
      `CHECK("interrupt on", 1'b1, int_oe);
      i_host.open_frame();
      @(negedge clk);
      hw_n = 1'b0;
      repeat (4) @(negedge clk);
      `CHECK("pin reset", 1'b1, hwa);
      `CHECK("reset lanes", 8'h00, io_oe);
      `CHECK("reset strobe", 1'b0, ds_oe);
      `CHECK("dfn ignores ball", 1'b0, hwa2);
      rx_count = 0;
      i_host.send_byte(WIDTH_X1, 1'b0, 8'h55);
      `CHECK("reset ignores bus", 0, rx_count);
      hw_n = 1'b1;
      txa = 1'b0;
      ev = 1'b0;
      i_host.close_frame();
      `CHECK("reset ends", 1'b0, hwa);
      `CHECK("interrupt off", 1'b0, int_oe);
      i_host.open_frame();
      i_host.send_byte(WIDTH_X1, 1'b0, 8'h96);
      i_host.close_frame();
      `CHECK("ready again", 8'h96, rx_last);
      $display("test interrupt and reset done");
   endtask : t_int_rst
   task automatic t_pkg();
      @(negedge clk);
      mw = WIDTH_X1;
      i_host.open_frame();
      i_host.io[3] = 1'b0;
      repeat (4) @(negedge clk);
      `CHECK("lane 3 reset", 1'b1, hwa2);
      `CHECK("ball ignores lane 3", 1'b0, hwa);
      mw = WIDTH_X4;
      repeat (4) @(negedge clk);
      `CHECK("lane 3 data in quad", 1'b0, hwa2);
      mw = WIDTH_X8;
      dtr = 1'b1;
      takes = 0;
      txa = 1'b1;
      repeat (4) @(negedge clk);
      `CHECK("octal lanes", LANES_X8, io_oe);
      `CHECK("quad only lanes", LANES_X4, oe2);
      `CHECK("octal first byte", 8'hC3, io_out);
      txd = 8'h5A;
      i_host.pulse_ck();
      `CHECK("octal next byte", 8'h5A, io_out);
      `CHECK("quad only nibble", 8'h05, out2);
      `CHECK("octal takes", 3, takes);
      txa = 1'b0;
      i_host.close_frame();
      $display("test package variants done");
   endtask : t_pkg
   initial begin
      {rst_n, dtr, ev, req, txa, mw, sr, txd} = '0;
      hw_n = 1'b1;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_rx();
      t_read();
      t_sr();
      t_int_rst();
      t_pkg();
      finish_test();
   end
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
endmodule : xspi_mem_pins_tb
bind xspi_mem_pins xspi_mem_pins_monitor i_mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CS_N(CS_N), .MODE_WIDTH(MODE_WIDTH),
   .EVENT_PENDING(EVENT_PENDING), .SR_WRITE_REQ(SR_WRITE_REQ), .SR_WRITE_GO(SR_WRITE_GO), .SR_LOCKED(SR_LOCKED),
   .IO_OE(IO_OE), .DS_OUT(DS_OUT), .DS_OE(DS_OE), .INT_OUT(INT_OUT), .INT_OE(INT_OE), .RX_VALID(RX_VALID),
   .FRAME_START(FRAME_START), .HW_RESET_ACTIVE(HW_RESET_ACTIVE));
